// ==== hw/hb_regs.svh ====
// Constants of the serial control port: bit positions, reset values, offsets, timing.
`ifndef HB_REGS_SVH
`define HB_REGS_SVH
`define HB_WORD_W          16
`define HB_SW_N            6
`define HB_BIT_CLEAR_REQ   0
`define HB_BIT_SW_LSB      1
`define HB_BIT_OC_ENABLE   13
`define HB_BIT_THERMAL     0
`define HB_BIT_SHORT       13
`define HB_BIT_OPEN        14
`define HB_BIT_SUPPLY      15
`define HB_CTRL_RESET      16'h2000
`define HB_OFS_TX_WORD     4'h0
`define HB_OFS_RX_WORD     4'h4
`define HB_OFS_CONTROL     4'h8
`define HB_OFS_STATUS      4'hc
`define HB_REF_PERIOD_NS   4
`define HB_SCLK_MIN_NS     500
`define HB_HALF_CYCLES     ((`HB_SCLK_MIN_NS + 2 * `HB_REF_PERIOD_NS - 1) / (2 * `HB_REF_PERIOD_NS))
`endif

// ==== hw/hb_pkg.sv ====
// Types shared by both ends of the serial control port.
`default_nettype none
`include "hb_regs.svh"
package hb_pkg;
    typedef logic [`HB_WORD_W-1:0] word_t;
    typedef logic [`HB_SW_N-1:0]   sw_t;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_LEAD  = 3'h1,
        ST_HIGH  = 3'h3,
        ST_LOW   = 3'h2,
        ST_TRAIL = 3'h6
    } host_state_t;
endpackage : hb_pkg
`default_nettype wire

// ==== hw/hb_link_if.sv ====
// Serial link between the host controller and the half-bridge driver port.
`default_nettype none
interface hb_link_if;
    logic cs_n_drv;
    logic cs_n_oe;
    logic sclk;
    logic serial_in;
    logic standby_drv;
    logic standby_oe;
    logic serial_out;
    logic serial_out_en;
    logic cs_n;
    logic standby_control;
    logic so_line;
    // Undriven select pulls up, undriven standby control pulls down.
    assign cs_n            = cs_n_oe ? cs_n_drv : 1'b1;
    assign standby_control = standby_oe ? standby_drv : 1'b0;
    // A released data line has no pull, so it shows the opposite of the device's output bit.
    assign so_line         = serial_out_en ? serial_out : ~serial_out;
    modport host (
        output cs_n_drv, cs_n_oe, sclk, serial_in, standby_drv, standby_oe,
        input  so_line
    );
    modport dev (
        input  cs_n, sclk, serial_in, standby_control,
        output serial_out, serial_out_en
    );
endinterface : hb_link_if
`default_nettype wire

// ==== hw/bit_sync.sv ====
// Two-flop synchroniser for level signals.
`default_nettype none
module bit_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } sync_t;
    sync_t s_q;
    sync_t s_d;

    always_comb begin
        s_d.meta = d;
        s_d.stab = s_q.meta;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.stab;
endmodule : bit_sync
`default_nettype wire

// ==== hw/hb_device.sv ====
// Driver end of the serial control port: shift registers, applied word, flags.
`default_nettype none
`include "hb_regs.svh"

////////////////////////////////////////////////////////////////////////////////

// Behaviour
// - Transfer starts at select fall; ignored while high.
// - Select low enables; undriven select reads high.
// - Host drives data; device samples on falling clock.
// - Control word is 16 bits, LSB first.
// - Host sends status clear request first.
// - New word applied only when select rises.
// - Data output released while select high.
// - Data output driven from select fall.
// - Output bit changes on rising clock only; the snapshot can still move it in the two system clocks after select fall.
// - Status word is 16 bits, LSB first.
// - First status bit is thermal warning.
// - Serial clock at most 2 MHz.
// - Standby when control low; undriven reads low.
// - Bit map: clear, six switches, overcurrent enable.
// - Clear request clears fault flags, not switches.
// - Status map: switches, short, open, supply.
// - Reset word: overcurrent enabled, switches off.
module hb_device
    import hb_pkg::*;
(
    input  wire logic  ref_clk,
    input  wire logic  rst_n,
    hb_link_if.dev     link,
    input  wire logic  thermal_warn_in,
    input  wire sw_t   short_event_in,
    input  wire logic  open_load_in,
    input  wire logic  supply_fail_in,
    output sw_t        switch_on,
    output logic       overcurrent_shutdown_enable,
    output logic       standby_active,
    output word_t      applied_word
);

    ////////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        word_t shift;
    } rx_t;

    typedef struct packed {
        logic [3:0] bit_idx;
        logic       armed;
    } tx_t;

    typedef struct packed {
        logic  cs_n_prev;
        word_t word;
        word_t snap;
        sw_t   short_off;
        sw_t   sw_out;
        logic  thermal_warning_flag;
        logic  short_fault_flag;
        logic  open_load_flag;
        logic  supply_fail_flag;
    } core_t;

    rx_t   rx_q;
    rx_t   rx_d;
    tx_t   tx_q;
    tx_t   tx_d;
    core_t c_q;
    core_t c_d;
    logic  cs_n_s;
    logic  sel_s;
    logic  standby_control_s;
    logic  tx_rst_n;
    logic  apply;
    sw_t   sw_live;
    word_t status;

    ////////////////////////////////////////////////////////////////////////////////

    // Receive side: samples on falling serial clock, only while selected.
    // Clocks seen while deselected belong to another device and are dropped.
    always_comb begin
        rx_d = rx_q;
        if (!link.cs_n) begin
            rx_d.shift = {link.serial_in, rx_q.shift[`HB_WORD_W-1:1]};
        end
    end

    always_ff @(negedge link.sclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_q <= '0;
        end else begin
            rx_q <= rx_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // Transmit side: the bit index is held at zero while deselected, so the
    // first status bit stands at the pin from the select fall onward.
    // A frame cut short leaves no stale index behind for the next one.
    assign tx_rst_n = rst_n & ~link.cs_n;

    // The first rising edge only arms the index, so bit 0 stays at the pin
    // through the first clock and the host can take it at the end of that clock's low phase.
    // Every later rising edge moves on one bit, which keeps sixteen distinct
    // bits in sixteen clocks instead of wrapping back to bit 0 at the end.
    always_comb begin
        tx_d.armed   = 1'b1;
        tx_d.bit_idx = tx_q.bit_idx;
        if (tx_q.armed) begin
            tx_d.bit_idx = tx_q.bit_idx + 4'h1;
        end
    end

    always_ff @(posedge link.sclk or negedge tx_rst_n) begin
        if (!tx_rst_n) begin
            tx_q <= '0;
        end else begin
            tx_q <= tx_d;
        end
    end

    assign link.serial_out    = c_q.snap[tx_q.bit_idx];
    assign link.serial_out_en = ~link.cs_n;

    ////////////////////////////////////////////////////////////////////////////////

    // Core side on the system clock. The received word stays still while
    // select is high and the serial clock is idle, so it is taken directly
    // once the synchronised select shows the rising edge.
    bit_sync #(
        .W (2)
    ) u_sync (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .d     ({~link.cs_n, link.standby_control}),
        .q     ({sel_s, standby_control_s})
    );

    // Select is carried inverted so that the synchroniser's reset level is the
    // idle level of the pin; otherwise a false select rise after reset would
    // apply the empty shift register and drop the overcurrent enable.
    assign cs_n_s  = ~sel_s;

    // A frame cut short is applied as it stands, like any other select rise.
    assign apply   = cs_n_s & ~c_q.cs_n_prev;
    assign sw_live = c_q.word[`HB_BIT_SW_LSB +: `HB_SW_N] & ~c_q.short_off
                     & {`HB_SW_N{standby_control_s}};

    always_comb begin
        status                    = '0;
        status[`HB_BIT_THERMAL]   = c_q.thermal_warning_flag;
        status[`HB_BIT_SW_LSB +: `HB_SW_N] = sw_live;
        status[`HB_BIT_SHORT]     = c_q.short_fault_flag;
        status[`HB_BIT_OPEN]      = c_q.open_load_flag;
        status[`HB_BIT_SUPPLY]    = c_q.supply_fail_flag;
    end

    always_comb begin
        logic clr;
        logic short_hit;
        clr       = 1'b0;
        short_hit = 1'b0;
        c_d       = c_q;
        c_d.cs_n_prev = cs_n_s;
        if (apply) begin
            c_d.word      = rx_q.shift;
            c_d.short_off = '0;
            clr           = rx_q.shift[`HB_BIT_CLEAR_REQ];
        end
        if (c_q.word[`HB_BIT_OC_ENABLE]) begin
            short_hit = |(short_event_in & sw_live);
            c_d.short_off = c_d.short_off | (short_event_in & sw_live);
        end
        // A fault arriving with the clear request still sets its flag.
        c_d.thermal_warning_flag = thermal_warn_in;
        c_d.short_fault_flag = (c_q.short_fault_flag & ~clr) | short_hit;
        c_d.open_load_flag   = (c_q.open_load_flag & ~clr)
                               | (open_load_in & |sw_live);
        c_d.supply_fail_flag = (c_q.supply_fail_flag & ~clr) | supply_fail_in;
        // Registered so the switch outputs never glitch while the terms settle.
        c_d.sw_out = sw_live;
        // The snapshot freezes during a frame so the shifted word is coherent.
        if (cs_n_s) begin
            c_d.snap = status;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            c_q           <= '0;
            c_q.cs_n_prev <= 1'b1;
            c_q.word      <= `HB_CTRL_RESET;
        end else begin
            c_q <= c_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // Outputs lag the synchronised pins by at most two system clocks (switch_on after a select rise); standby_active follows them directly.
    assign switch_on                   = c_q.sw_out;
    assign overcurrent_shutdown_enable = c_q.word[`HB_BIT_OC_ENABLE];
    assign standby_active              = ~standby_control_s;
    assign applied_word                = c_q.word;

endmodule : hb_device
`default_nettype wire

// ==== hw/hb_host.sv ====
// Host end: AHB-Lite register slave that runs 16-bit frames on the serial link.
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`default_nettype none
`include "hb_regs.svh"
module hb_host
    import hb_pkg::*;
#(
    parameter int HALF = `HB_HALF_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    hb_link_if.host          link
);

    typedef struct packed {
        host_state_t st;
        logic [7:0]  cnt;
        logic [3:0]  bit_idx;
        word_t       tx_sh;
        word_t       rx_sh;
        word_t       tx_word;
        word_t       rx_word;
        logic        normal;
        logic        done;
        logic        cs_n;
        logic        sclk;
        logic        sdata;
        logic        wr;
        logic [3:0]  addr;
        logic [31:0] rdata;
    } host_t;

    localparam logic [7:0] HALF_M1 = 8'(HALF - 1);

    host_t h_q;
    host_t h_d;
    logic  so_s;
    logic  ap;
    logic  start;

    bit_sync #(
        .W (1)
    ) u_sync (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .d     (link.so_line),
        .q     (so_s)
    );

    ////////////////////////////////////////////////////////////////////////////////

    // Zero-wait slave: read data are loaded at the address phase edge.
    // Only the first sixteen bytes decode, so higher addresses do not alias.
    assign ap    = hsel & htrans[1] & hready & (hsize == 3'h2) & (haddr[31:4] == 28'h0);
    assign start = h_q.wr & (h_q.addr == `HB_OFS_CONTROL) & hwdata[0] & (h_q.st == ST_IDLE);

    always_comb begin
        h_d       = h_q;
        h_d.wr    = ap & hwrite;
        h_d.addr  = haddr[3:0];
        h_d.rdata = '0;
        if (ap & ~hwrite) begin
            unique case (haddr[3:0])
                `HB_OFS_TX_WORD: h_d.rdata = {16'h0000, h_q.tx_word};
                `HB_OFS_RX_WORD: h_d.rdata = {16'h0000, h_q.rx_word};
                `HB_OFS_CONTROL: h_d.rdata = {30'h0, h_q.normal, 1'b0};
                `HB_OFS_STATUS:  h_d.rdata = {30'h0, h_q.done, h_q.st != ST_IDLE};
                default:         h_d.rdata = '0;
            endcase
        end
        if (h_q.wr && h_q.addr == `HB_OFS_TX_WORD && h_q.st == ST_IDLE) begin
            h_d.tx_word = hwdata[15:0];
        end
        if (h_q.wr && h_q.addr == `HB_OFS_CONTROL) begin
            h_d.normal = hwdata[1];
        end
        h_d.cnt = h_q.cnt - 8'h1;
        unique case (h_q.st)
            ST_IDLE: begin
                if (start) begin
                    h_d.st      = ST_LEAD;
                    h_d.cs_n    = 1'b0;
                    h_d.done    = 1'b0;
                    h_d.cnt     = HALF_M1;
                    h_d.bit_idx = 4'h0;
                    h_d.tx_sh   = h_q.tx_word;
                    h_d.sdata   = h_q.tx_word[0];
                end
            end
            ST_LEAD: begin
                if (h_q.cnt == 8'h0) begin
                    h_d.st   = ST_HIGH;
                    h_d.sclk = 1'b1;
                    h_d.cnt  = HALF_M1;
                end
            end
            ST_HIGH: begin
                if (h_q.cnt == 8'h0) begin
                    h_d.st   = ST_LOW;
                    h_d.sclk = 1'b0;
                    h_d.cnt  = HALF_M1;
                end
            end
            ST_LOW: begin
                if (h_q.cnt == 8'h0) begin
                    h_d.rx_sh = {so_s, h_q.rx_sh[15:1]};
                    h_d.cnt   = HALF_M1;
                    if (h_q.bit_idx == 4'hf) begin
                        h_d.st = ST_TRAIL;
                    end else begin
                        h_d.st      = ST_HIGH;
                        h_d.sclk    = 1'b1;
                        h_d.bit_idx = h_q.bit_idx + 4'h1;
                        h_d.tx_sh   = h_q.tx_sh >> 1;
                        h_d.sdata   = h_q.tx_sh[1];
                    end
                end
            end
            ST_TRAIL: begin
                if (h_q.cnt == 8'h0) begin
                    h_d.st      = ST_IDLE;
                    h_d.cs_n    = 1'b1;
                    h_d.done    = 1'b1;
                    h_d.rx_word = h_q.rx_sh;
                end
            end
            default: h_d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            h_q      <= '0;
            h_q.cs_n <= 1'b1;
        end else begin
            h_q <= h_d;
        end
    end

    assign hreadyout        = 1'b1;
    assign hresp            = 1'b0;
    assign hrdata           = h_q.rdata;
    assign link.cs_n_drv    = h_q.cs_n;
    assign link.cs_n_oe     = 1'b1;
    assign link.sclk        = h_q.sclk;
    assign link.serial_in   = h_q.sdata;
    assign link.standby_drv = h_q.normal;
    assign link.standby_oe  = 1'b1;
endmodule : hb_host
`default_nettype wire

// ==== dv/hb_link_asserts.sv ====
// Checker of the serial link between the host end and the driver end.
`default_nettype none
module hb_link_asserts #(
    parameter int HALF = 63
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_en
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] hi_q;
    logic [4:0] edge_q;

    // Counting in helper logic keeps the repetitions short for the tools.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_q   <= 8'h00;
            edge_q <= 5'h00;
        end else begin
            hi_q   <= sclk ? hi_q + 8'h01 : 8'h00;
            edge_q <= cs_n ? 5'h00 : edge_q + {4'h0, sclk & (hi_q == 8'h00)};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence lead_s;
        !sclk [*4];
    endsequence

    sequence open_s;
        $fell(cs_n) ##0 serial_out_en;
    endsequence

    a_out_released: assert property (cs_n |-> !serial_out_en)
        else $error("data output driven while deselected");
    a_out_driven: assert property (!cs_n |-> serial_out_en)
        else $error("data output not driven while selected");
    a_frame_open: assert property ($fell(cs_n) |-> open_s ##1 lead_s)
        else $error("serial clock moved too soon after select fell");
    a_out_on_rise: assert property ($changed(serial_out) && !cs_n && !$past(cs_n, 6) |-> sclk)
        else $error("data output changed outside a high clock phase");
    a_data_stable: assert property (sclk && $past(sclk) && !cs_n |-> $stable(serial_in))
        else $error("data input moved while the clock was high");
    a_clk_half: assert property ($fell(sclk) |-> hi_q == 8'(HALF))
        else $error("clock high phase of the wrong length");
    a_sixteen_bits: assert property ($rose(cs_n) |-> edge_q == 5'h10)
        else $error("frame did not carry sixteen clocks");
    a_idle_clk_low: assert property (cs_n |-> !sclk)
        else $error("clock active while deselected");
endmodule : hb_link_asserts
`default_nettype wire

// ==== dv/tb_top.sv ====
// Bench joining host and driver ends over the serial link.
`default_nettype none
`include "hb_regs.svh"
module tb_top import hb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = `HB_HALF_CYCLES;
    localparam logic [7:0] A_TX = 8'(`HB_OFS_TX_WORD);
    localparam logic [7:0] A_RX = 8'(`HB_OFS_RX_WORD);
    localparam logic [7:0] A_CT = 8'(`HB_OFS_CONTROL);
    localparam logic [7:0] A_ST = 8'(`HB_OFS_STATUS);
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        thermal = 1'b0;
    sw_t         shorts = 6'h00;
    logic        open_ld = 1'b0;
    logic        supply_low = 1'b0;
    sw_t         switch_on;
    logic        oc_en;
    logic        standby_active;
    word_t       applied_word;
    logic [31:0] rd;
    int          failures = 0;
    int          checked = 0;
    int          cycles = 0;

    ////////////////////////////////////////////////////////////////////////////////
    hb_link_if hb_link_if_i ();
    hb_host #(.HALF(HALF)) hb_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .link(hb_link_if_i));
    hb_device hb_device_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(hb_link_if_i),
        .thermal_warn_in(thermal), .short_event_in(shorts), .open_load_in(open_ld),
        .supply_fail_in(supply_low), .switch_on(switch_on),
        .overcurrent_shutdown_enable(oc_en), .standby_active(standby_active),
        .applied_word(applied_word));
    hb_link_asserts #(.HALF(HALF)) hb_link_asserts_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .cs_n(hb_link_if_i.cs_n), .sclk(hb_link_if_i.sclk),
        .serial_in(hb_link_if_i.serial_in), .serial_out(hb_link_if_i.serial_out),
        .serial_out_en(hb_link_if_i.serial_out_en));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    // The ceiling allows a few times the expected run, so a stuck poll ends the run.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic frame(input word_t tx, input word_t exp_rx);
        word_t prior;
        prior = applied_word;
        ahb(1'b1, A_TX, {16'h0, tx});
        ahb(1'b1, A_CT, 32'h3);
        repeat (1000) @(posedge ref_clk);
        chk(32'(hb_link_if_i.cs_n), 32'h0, "select in frame");
        chk(32'(applied_word), 32'(prior), "word held in frame");
        do ahb(1'b0, A_ST, 32'h0); while (rd[1] !== 1'b1);
        ahb(1'b0, A_RX, 32'h0);
        chk(rd, {16'h0, exp_rx}, "status word");
        repeat (4) @(posedge ref_clk);
        chk(32'(applied_word), 32'(tx), "applied word");
    endtask : frame

    task automatic check_reset;
        chk(32'(applied_word), 32'(`HB_CTRL_RESET), "reset word");
        chk(32'({oc_en, switch_on, standby_active}), 32'h81, "reset outputs");
        chk(32'(hresp), 32'h0, "okay response");
        ahb(1'b1, 8'h10, 32'hffff_ffff);
        ahb(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        ahb(1'b1, A_RX, 32'h0000_5555);
        ahb(1'b0, A_RX, 32'h0);
        chk(rd, 32'h0, "receive word is read only");
    endtask : check_reset

    task automatic check_standby;
        ahb(1'b1, A_CT, 32'h2);
        repeat (6) @(posedge ref_clk);
        chk(32'(standby_active), 32'h0, "normal operation");
    endtask : check_standby

    task automatic check_switches;
        thermal <= 1'b1;
        repeat (6) @(posedge ref_clk);
        frame(16'h007e, 16'h0001);
        chk(32'({oc_en, switch_on}), 32'h3f, "all switches on");
    endtask : check_switches

    task automatic check_flags;
        thermal <= 1'b0;
        open_ld <= 1'b1;
        supply_low <= 1'b1;
        repeat (6) @(posedge ref_clk);
        frame(16'h2000, 16'hc07e);
        open_ld <= 1'b0;
        supply_low <= 1'b0;
        frame(16'h2001, 16'hc000);
        frame(16'h2002, 16'h0000);
        chk(32'({oc_en, switch_on}), 32'h41, "one switch on");
    endtask : check_flags

    task automatic check_short;
        // Shutdown latches, so the event may be released before the next frame.
        shorts <= 6'h01;
        repeat (6) @(posedge ref_clk);
        chk(32'(switch_on), 32'h0, "shorted switch off");
        shorts <= 6'h00;
        frame(16'h2002, 16'h2000);
        chk(32'(switch_on), 32'h01, "switch back on");
        ahb(1'b1, A_CT, 32'h0);
        repeat (6) @(posedge ref_clk);
        chk(32'({standby_active, switch_on}), 32'h40, "standby forces switches off");
    endtask : check_short

    task automatic test_done;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    initial begin
        // Reset starts high and is lowered by a nonblocking assignment at time zero so every flop sees a true falling edge.
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        check_reset();
        check_standby();
        check_switches();
        check_flags();
        check_short();
        test_done();
    end
endmodule : tb_top
`default_nettype wire
